/* File: hw/ecwm_pkg.sv */
// shared constants, types and the word-to-field mapping of the configuration word mapper
package ecwm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int ECWM_PORTS = 4;
    localparam int ECWM_WORDS = 10;
    localparam int ECWM_PORT_W = 2;
    localparam int ECWM_CNT_W = 4;

    // image word byte addresses covered by this block
    localparam logic [7:0] ECWM_ADDR_FIRST = 8'h0C;
    localparam logic [7:0] ECWM_ADDR_LAST  = 8'h1E;

    // index of each image word inside the shadow store
    localparam int W_CTRL   = 0;   // word 0Ch
    localparam int W_MARGIN = 1;   // word 0Eh
    localparam int W_NOMDRV = 2;   // word 10h
    localparam int W_NOMEMP = 3;   // word 12h
    localparam int W_PHY2   = 4;   // word 14h
    localparam int W_V4LO   = 5;   // word 16h
    localparam int W_V4HI   = 6;   // word 18h
    localparam int W_V5LO   = 7;   // word 1Ah
    localparam int W_V5HI   = 8;   // word 1Ch
    localparam int W_PHY3   = 9;   // word 1Eh

    typedef logic [ECWM_WORDS-1:0][15:0] ecwm_image_type;

    // defaults, highest index first
    localparam ecwm_image_type ECWM_IMAGE_DEFAULT = {
        16'h0000, 16'h7B08, 16'h3333, 16'h0000, 16'h0000,
        16'hC0A7, 16'hF6B5, 16'h0A73, 16'h916B, 16'h001D
    };

    ////////////////////////////////////////////////////////////////////////////////
    // source bit positions inside the image words
    localparam int B_ORDER_FREEZE = 10;
    localparam int B_SOF_LATENCY  = 11;
    localparam int B_SURPRISE     = 12;
    localparam int B_PM_DSEL      = 13;
    localparam int B_LTR          = 14;
    localparam int B_TOP          = 15;
    localparam int LVL_W          = 5;
    localparam int LVL0_LSB       = 0;
    localparam int LVL1_LSB       = 5;
    localparam int LVL2_LSB       = 10;
    localparam int PHYLAT_LSB     = 0;
    localparam int PHYLAT_W       = 4;
    localparam int RXDET_LSB      = 4;
    localparam int RXDET_W        = 3;
    localparam int HDELTA_LSB     = 7;
    localparam int HDELTA_W       = 5;
    localparam int CTRL6_MID_LSB  = 12;
    localparam int CTRL6_MID_W    = 4;
    localparam int V5HI_LSB       = 0;
    localparam int V5HI_W         = 8;
    localparam int CTRL6_TOP_LSB  = 8;
    localparam int CTRL6_TOP_W    = 3;
    localparam int REFCLK_LSB     = 11;
    localparam int REFCLK_W       = 5;
    localparam int PHY3_LSB       = 0;
    localparam int PHY3_W         = 12;
    localparam int MAC_LSB        = 12;
    localparam int MAC_W          = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // per-port fields; prefix gives the configuration offset they land in
    typedef struct packed {
        logic        cc_order_frozen;                  // CCh[21]
        logic        cc_pm_data_select_rw;             // CCh[19]
        logic        r8c_alt_rate2_phy_mode;           // 8Ch[31]
        logic [3:0]  r8c_mac_ctrl;                     // 8Ch[29:26]
        logic [7:0]  r8c_vendor_phy_ctrl_word6;        // 8Ch[23:16]
        logic        r8c_sof_latency_mode;             // 8Ch[6]
        logic        r8c_ltr_en;                       // 8Ch[1]
        logic        r8c_surprise_down_en;             // 8Ch[0]
        logic        e4_obff_en;                       // E4h[18]
        logic        e4_boundary_check_en;             // E4h[12]
        logic [4:0]  r94_margin_drive_level_halfswing;   // 94h[14:10]
        logic [4:0]  r94_margin_drive_level_highdeemph;  // 94h[9:5]
        logic [4:0]  r94_margin_drive_level_lowdeemph;   // 94h[4:0]
        logic [4:0]  r74_nominal_drive_level_halfswing;  // 74h[30:26]
        logic [4:0]  r74_nominal_drive_level_highdeemph; // 74h[25:21]
        logic [4:0]  r74_nominal_drive_level_lowdeemph;  // 74h[20:16]
        logic [4:0]  r78_nominal_emphasis_rate2_high;  // 78h[30:26]
        logic [4:0]  r78_nominal_emphasis_rate2_low;   // 78h[25:21]
        logic [4:0]  r78_nominal_emphasis_rate1;       // 78h[20:16]
        logic [2:0]  r7c_receiver_detect_time;         // 7Ch[6:4]
        logic [3:0]  r7c_transmit_phy_latency;         // 7Ch[3:0]
        logic [11:0] r90_phy_param3_deltas;            // 90h[31:20]
        logic [4:0]  r90_halfswing_emphasis_delta;     // 90h[19:15]
        logic [31:0] r84_vendor_phy_ctrl_word4;        // 84h[31:0]
        logic [23:0] r88_vendor_phy_ctrl_word5;        // 88h[23:0]
        logic [4:0]  r98_refclk_buffer_ctrl;           // 98h[20:16]
    } ecwm_port_cfg_type;

    typedef ecwm_port_cfg_type [ECWM_PORTS-1:0] ecwm_cfg_array_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COLLECT,
        ST_APPLY,
        ST_DONE
    } ecwm_state_type;

    ////////////////////////////////////////////////////////////////////////////////
    // fixed address-to-field mapping, shared by the loader and the reset value
    function automatic ecwm_port_cfg_type ecwm_map_image(input ecwm_image_type w);
        ecwm_port_cfg_type c;
        c = '0;
        c.cc_order_frozen                   = w[W_CTRL][B_ORDER_FREEZE];
        c.r8c_sof_latency_mode              = w[W_CTRL][B_SOF_LATENCY];
        c.r8c_surprise_down_en              = w[W_CTRL][B_SURPRISE];
        c.cc_pm_data_select_rw              = w[W_CTRL][B_PM_DSEL];
        c.r8c_ltr_en                        = w[W_CTRL][B_LTR];
        c.e4_boundary_check_en              = w[W_CTRL][B_TOP];
        c.r94_margin_drive_level_lowdeemph  = w[W_MARGIN][LVL0_LSB +: LVL_W];
        c.r94_margin_drive_level_highdeemph = w[W_MARGIN][LVL1_LSB +: LVL_W];
        c.r94_margin_drive_level_halfswing  = w[W_MARGIN][LVL2_LSB +: LVL_W];
        c.e4_obff_en                        = w[W_MARGIN][B_TOP];
        c.r74_nominal_drive_level_lowdeemph  = w[W_NOMDRV][LVL0_LSB +: LVL_W];
        c.r74_nominal_drive_level_highdeemph = w[W_NOMDRV][LVL1_LSB +: LVL_W];
        c.r74_nominal_drive_level_halfswing  = w[W_NOMDRV][LVL2_LSB +: LVL_W];
        c.r8c_alt_rate2_phy_mode            = w[W_NOMDRV][B_TOP];
        c.r78_nominal_emphasis_rate1        = w[W_NOMEMP][LVL0_LSB +: LVL_W];
        c.r78_nominal_emphasis_rate2_low    = w[W_NOMEMP][LVL1_LSB +: LVL_W];
        c.r78_nominal_emphasis_rate2_high   = w[W_NOMEMP][LVL2_LSB +: LVL_W];
        c.r7c_transmit_phy_latency          = w[W_PHY2][PHYLAT_LSB +: PHYLAT_W];
        c.r7c_receiver_detect_time          = w[W_PHY2][RXDET_LSB +: RXDET_W];
        c.r90_halfswing_emphasis_delta      = w[W_PHY2][HDELTA_LSB +: HDELTA_W];
        // word6 bit 0, bits 4:1 and bits 7:5 come from three different image words
        c.r8c_vendor_phy_ctrl_word6 = {w[W_V5HI][CTRL6_TOP_LSB +: CTRL6_TOP_W],
                                       w[W_PHY2][CTRL6_MID_LSB +: CTRL6_MID_W],
                                       w[W_NOMEMP][B_TOP]};
        c.r84_vendor_phy_ctrl_word4 = {w[W_V4HI], w[W_V4LO]};
        c.r88_vendor_phy_ctrl_word5 = {w[W_V5HI][V5HI_LSB +: V5HI_W], w[W_V5LO]};
        c.r98_refclk_buffer_ctrl    = w[W_V5HI][REFCLK_LSB +: REFCLK_W];
        c.r90_phy_param3_deltas     = w[W_PHY3][PHY3_LSB +: PHY3_W];
        c.r8c_mac_ctrl              = w[W_PHY3][MAC_LSB +: MAC_W];
        return c;
    endfunction

    localparam ecwm_port_cfg_type ECWM_CFG_RESET = ecwm_map_image(ECWM_IMAGE_DEFAULT);

endpackage

/* File: hw/ecwm_word_store.sv */
// shadow store of image words 0Ch..1Eh, preset to their defaults
`timescale 1ns/1ps
`default_nettype none
module ecwm_word_store (
    // clock and reset
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rstn,
    // write side
    input  wire logic                    i_wr,
    input  wire logic [3:0]              i_wr_idx,
    input  wire logic [15:0]             i_wr_data,
    // image
    output ecwm_pkg::ecwm_image_type     o_image
);
    import ecwm_pkg::*;

    logic [15:0] word_reg  [ECWM_WORDS];
    logic [15:0] word_next [ECWM_WORDS];

    genvar gi;
    generate
        for (gi = 0; gi < ECWM_WORDS; gi++) begin : g_word
            always_comb begin
                word_next[gi] = word_reg[gi];
                if (i_wr && (i_wr_idx == 4'(gi))) begin
                    word_next[gi] = i_wr_data;
                end
            end

            // untouched words keep their stored value; reset loads the default
            always_ff @(posedge i_sys_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    word_reg[gi] <= ECWM_IMAGE_DEFAULT[gi];
                end else begin
                    word_reg[gi] <= word_next[gi];
                end
            end

            assign o_image[gi] = word_reg[gi];
        end
    endgenerate

endmodule
`default_nettype wire

/* File: hw/ecwm_port_slot.sv */
// one port's loaded configuration fields
`timescale 1ns/1ps
`default_nettype none
module ecwm_port_slot (
    // clock and reset
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rstn,
    // load
    input  wire logic                      i_load,
    input  wire ecwm_pkg::ecwm_port_cfg_type i_cfg,
    // fields
    output ecwm_pkg::ecwm_port_cfg_type    o_cfg
);
    import ecwm_pkg::*;

    ecwm_port_cfg_type cfg_reg;
    ecwm_port_cfg_type cfg_next;

    always_comb begin
        cfg_next = cfg_reg;
        if (i_load) begin
            cfg_next = i_cfg;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_reg <= ECWM_CFG_RESET;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    assign o_cfg = cfg_reg;

endmodule
`default_nettype wire

/* File: hw/ecwm_config_loader.sv */
// configuration loader: collects image words and writes them into every port's fields
`timescale 1ns/1ps
`default_nettype none
module ecwm_config_loader (
    // clock and reset
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rstn,
    // from the serial memory reader
    input  wire logic                      i_load_start,
    input  wire logic                      i_image_valid,
    input  wire logic                      i_word_valid,
    input  wire logic [7:0]                i_word_addr,
    input  wire logic [15:0]               i_word_data,
    input  wire logic                      i_load_end,
    // per-port configuration fields
    output ecwm_pkg::ecwm_cfg_array_type   o_port_cfg,
    // status
    output logic                           o_load_busy,
    output logic                           o_load_done,
    output logic                           o_image_used,
    output logic [3:0]                     o_words_taken
);
    import ecwm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer state
    ecwm_state_type         state_reg;
    ecwm_state_type         state_next;
    logic [ECWM_PORT_W-1:0] port_reg;
    logic [ECWM_PORT_W-1:0] port_next;
    logic                   busy_reg;
    logic                   busy_next;
    logic                   done_reg;
    logic                   done_next;
    logic                   used_reg;
    logic                   used_next;
    logic [ECWM_CNT_W-1:0]  count_reg;
    logic [ECWM_CNT_W-1:0]  count_next;

    logic                   word_in_range;
    logic                   word_take;
    logic [3:0]             word_idx;
    logic [7:0]             word_offset;
    ecwm_image_type         image;
    ecwm_port_cfg_type      mapped_cfg;

    ////////////////////////////////////////////////////////////////////////////////
    // word acceptance: only even addresses inside the covered span, only from a
    // valid image; anything else is dropped so the stored words survive
    always_comb begin
        word_offset   = i_word_addr - ECWM_ADDR_FIRST;
        word_idx      = word_offset[4:1];
        word_in_range = (i_word_addr >= ECWM_ADDR_FIRST) && (i_word_addr <= ECWM_ADDR_LAST)
                        && !i_word_addr[0];
        word_take     = (state_reg == ST_COLLECT) && i_word_valid && word_in_range
                        && i_image_valid;
    end

    ecwm_word_store u_store (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_wr      (word_take),
        .i_wr_idx  (word_idx),
        .i_wr_data (i_word_data),
        .o_image   (image)
    );

    assign mapped_cfg = ecwm_map_image(image);

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer: collect words, then write one port per cycle
    always_comb begin
        state_next = state_reg;
        port_next  = port_reg;
        busy_next  = busy_reg;
        done_next  = done_reg;
        used_next  = used_reg;
        count_next = count_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (i_load_start) begin
                    state_next = ST_COLLECT;
                    busy_next  = 1'b1;
                    done_next  = 1'b0;
                    used_next  = 1'b0;
                    count_next = '0;
                end
            end
            ST_COLLECT: begin
                if (word_take) begin
                    count_next = count_reg + 4'(1);
                    used_next  = 1'b1;
                end
                // a word in the same cycle as the end is still stored first
                if (i_load_end) begin
                    state_next = ST_APPLY;
                    port_next  = '0;
                end
            end
            ST_APPLY: begin
                port_next = port_reg + 2'(1);
                if (port_reg == 2'(ECWM_PORTS - 1)) begin
                    state_next = ST_DONE;
                    busy_next  = 1'b0;
                    done_next  = 1'b1;
                end
            end
            ST_DONE: begin
                // a new start reloads; done drops until all ports are rewritten
                if (i_load_start) begin
                    state_next = ST_COLLECT;
                    busy_next  = 1'b1;
                    done_next  = 1'b0;
                    used_next  = 1'b0;
                    count_next = '0;
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= ST_IDLE;
            port_reg  <= '0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
            used_reg  <= 1'b0;
            count_reg <= '0;
        end else begin
            state_reg <= state_next;
            port_reg  <= port_next;
            busy_reg  <= busy_next;
            done_reg  <= done_next;
            used_reg  <= used_next;
            count_reg <= count_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-port fields: same mapped value into every port
    genvar gp;
    generate
        for (gp = 0; gp < ECWM_PORTS; gp++) begin : g_port
            ecwm_port_slot u_slot (
                .i_sys_clk (i_sys_clk),
                .i_rstn    (i_rstn),
                .i_load    ((state_reg == ST_APPLY) && (port_reg == 2'(gp))),
                .i_cfg     (mapped_cfg),
                .o_cfg     (o_port_cfg[gp])
            );
        end
    endgenerate

    assign o_load_busy   = busy_reg;
    assign o_load_done   = done_reg;
    assign o_image_used  = used_reg;
    assign o_words_taken = count_reg;

endmodule
`default_nettype wire

/* File: tb/ecwm_loader_props.sv */
// timing and ordering checks on the configuration loader ports
`timescale 1ns/1ps
`default_nettype none
module ecwm_loader_props (
    // clock and reset
    input wire logic                         i_sys_clk,
    input wire logic                         i_rstn,
    // reader side
    input wire logic                         i_load_start,
    input wire logic                         i_image_valid,
    input wire logic                         i_word_valid,
    input wire logic [7:0]                   i_word_addr,
    input wire logic [15:0]                  i_word_data,
    input wire logic                         i_load_end,
    // results
    input wire ecwm_pkg::ecwm_cfg_array_type i_port_cfg_seen,
    input wire logic                         o_load_busy,
    input wire logic                         o_load_done,
    input wire logic                         o_image_used,
    input wire logic [3:0]                   o_words_taken
);
    import ecwm_pkg::*;
    logic collect_reg;
    logic collect_next;
    logic takes;

    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the collecting phase, so checks need no view of the body
    always_comb begin
        collect_next = collect_reg;
        if (i_load_start && !o_load_busy) begin
            collect_next = 1'b1;
        end else if (i_load_end) begin
            collect_next = 1'b0;
        end
        takes = collect_reg && i_word_valid && i_image_valid && !i_word_addr[0]
                && i_word_addr >= 8'h0C && i_word_addr <= 8'h1E;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            collect_reg <= 1'b0;
        end else begin
            collect_reg <= collect_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    start_accept_a: assert property (i_load_start && !o_load_busy |=> o_load_busy && !o_load_done
        && o_words_taken == 4'h0 && !o_image_used) else $error("start not answered");
    word_take_a: assert property (takes |=> (o_words_taken - $past(o_words_taken)) == 4'h1
        && o_image_used) else $error("word not counted");
    word_drop_a: assert property (collect_reg && !takes |=> $stable(o_words_taken))
        else $error("refused word counted");
    done_time_a: assert property (collect_reg && i_load_end |-> ##5 !o_load_busy && o_load_done)
        else $error("done not five cycles after end");
    last_port_a: assert property (collect_reg && i_load_end |=> $stable(i_port_cfg_seen[3])[*4])
        else $error("port 3 written too early");
    collect_quiet_a: assert property (collect_reg |=> $stable(i_port_cfg_seen))
        else $error("fields moved before apply");
    ports_equal_a: assert property (o_load_done |-> i_port_cfg_seen[0] == i_port_cfg_seen[1]
        && i_port_cfg_seen[1] == i_port_cfg_seen[2] && i_port_cfg_seen[2] == i_port_cfg_seen[3])
        else $error("ports differ at done");
    done_hold_a: assert property (o_load_done && !i_load_start |=> o_load_done && !o_load_busy)
        else $error("done dropped");

    load_cov: cover property (collect_reg && i_load_end ##5 o_load_done);
    take_cov: cover property (takes);
    end_word_cov: cover property (takes && i_load_end);
endmodule

bind ecwm_config_loader ecwm_loader_props ecwm_loader_props_inst (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_load_start(i_load_start),
    .i_image_valid(i_image_valid), .i_word_valid(i_word_valid), .i_word_addr(i_word_addr),
    .i_word_data(i_word_data), .i_load_end(i_load_end), .i_port_cfg_seen(o_port_cfg),
    .o_load_busy(o_load_busy), .o_load_done(o_load_done), .o_image_used(o_image_used),
    .o_words_taken(o_words_taken));
`default_nettype wire

/* File: tb/ecwm_eeprom_model.sv */
// serial memory reader stand-in: streams image words into the loader
`timescale 1ns/1ps
`default_nettype none
module ecwm_eeprom_model (
    // clock
    input  wire logic        i_sys_clk,
    // loader inputs
    output logic             o_load_start,
    output logic             o_image_valid,
    output logic             o_word_valid,
    output logic [7:0]       o_word_addr,
    output logic [15:0]      o_word_data,
    output logic             o_load_end
);
    import ecwm_pkg::*;
    initial begin
        o_load_start = 1'b0;
        o_image_valid = 1'b0;
        o_word_valid = 1'b0;
        o_word_addr = 8'h00;
        o_word_data = 16'h0000;
        o_load_end = 1'b0;
    end

    // released lines show the inverse so a stale value never looks valid
    task automatic put(input logic [7:0] a, input logic [15:0] d);
        o_word_valid <= 1'b1;
        o_word_addr <= a;
        o_word_data <= d;
        @(posedge i_sys_clk);
    endtask

    // slow mode leaves a gap after every image word; junk adds unmapped addresses
    task automatic send(input ecwm_image_type img, input logic good, input logic slow,
                        input logic junk);
        // requests start on a rising edge, never mid-cycle
        @(posedge i_sys_clk);
        o_image_valid <= good;
        o_load_start <= 1'b1;
        @(posedge i_sys_clk);
        o_load_start <= 1'b0;
        for (int k = 0; k < ECWM_WORDS; k++) begin
            if (junk) begin
                put(8'h0D + 8'(2 * k), ~img[k]);
                put(8'h20 + 8'(2 * k), ~img[k]);
                put(8'h0A, ~img[k]);
            end
            // fast mode ends the load in the cycle of the last word
            o_load_end <= !slow && (k == ECWM_WORDS - 1);
            put(8'h0C + 8'(2 * k), img[k]);
            if (slow) begin
                o_word_valid <= 1'b0;
                o_word_addr <= ~o_word_addr;
                o_word_data <= ~o_word_data;
                @(posedge i_sys_clk);
            end
        end
        o_word_valid <= 1'b0;
        o_word_addr <= ~o_word_addr;
        o_word_data <= ~o_word_data;
        if (slow) begin
            o_load_end <= 1'b1;
            @(posedge i_sys_clk);
        end
        o_load_end <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_ecwm_config_loader.sv */
// self-checking bench for the configuration word mapper
`timescale 1ns/1ps
`default_nettype none
module tb_ecwm_config_loader;
    import ecwm_pkg::*;
    localparam int CW = $bits(ecwm_port_cfg_type);
    localparam ecwm_image_type IMG_DEF = {16'h0000, 16'h7B08, 16'h3333, 16'h0000, 16'h0000,
                                          16'hC0A7, 16'hF6B5, 16'h0A73, 16'h916B, 16'h001D};
    localparam ecwm_image_type IMG_A = {16'hA55A, 16'h5AA5, 16'hC3C3, 16'h3C3C, 16'h9696,
                                        16'h6969, 16'hF00F, 16'h0FF0, 16'hAAAA, 16'h5555};
    logic               i_sys_clk;
    logic               i_rstn;
    logic               ld_start;
    logic               img_valid;
    logic               wd_valid;
    logic [7:0]         wd_addr;
    logic [15:0]        wd_data;
    logic               ld_end;
    ecwm_cfg_array_type o_port_cfg;
    logic               o_load_busy;
    logic               o_load_done;
    logic               o_image_used;
    logic [3:0]         o_words_taken;
    int                 failures;
    int                 total_checks;
    int                 cycles;

    ecwm_config_loader ecwm_config_loader_inst (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_load_start(ld_start),
        .i_image_valid(img_valid), .i_word_valid(wd_valid), .i_word_addr(wd_addr),
        .i_word_data(wd_data), .i_load_end(ld_end), .o_port_cfg(o_port_cfg),
        .o_load_busy(o_load_busy), .o_load_done(o_load_done), .o_image_used(o_image_used),
        .o_words_taken(o_words_taken));

    ecwm_eeprom_model ecwm_eeprom_model_inst (
        .i_sys_clk(i_sys_clk), .o_load_start(ld_start), .o_image_valid(img_valid),
        .o_word_valid(wd_valid), .o_word_addr(wd_addr), .o_word_data(wd_data),
        .o_load_end(ld_end));

    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [CW-1:0] seen, input logic [CW-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // field placement worked out bit by bit from the mapping table
    function automatic ecwm_port_cfg_type exp_map(input ecwm_image_type w);
        ecwm_port_cfg_type c;
        c = '0;
        {c.e4_boundary_check_en, c.r8c_ltr_en, c.cc_pm_data_select_rw, c.r8c_surprise_down_en,
         c.r8c_sof_latency_mode, c.cc_order_frozen} = w[0][15:10];
        {c.e4_obff_en, c.r94_margin_drive_level_halfswing, c.r94_margin_drive_level_highdeemph,
         c.r94_margin_drive_level_lowdeemph} = w[1];
        {c.r8c_alt_rate2_phy_mode, c.r74_nominal_drive_level_halfswing,
         c.r74_nominal_drive_level_highdeemph, c.r74_nominal_drive_level_lowdeemph} = w[2];
        {c.r78_nominal_emphasis_rate2_high, c.r78_nominal_emphasis_rate2_low,
         c.r78_nominal_emphasis_rate1} = w[3][14:0];
        {c.r7c_receiver_detect_time, c.r7c_transmit_phy_latency} = w[4][6:0];
        c.r90_halfswing_emphasis_delta = w[4][11:7];
        c.r8c_vendor_phy_ctrl_word6 = {w[8][10:8], w[4][15:12], w[3][15]};
        c.r84_vendor_phy_ctrl_word4 = {w[6], w[5]};
        c.r88_vendor_phy_ctrl_word5 = {w[8][7:0], w[7]};
        c.r98_refclk_buffer_ctrl = w[8][15:11];
        {c.r8c_mac_ctrl, c.r90_phy_param3_deltas} = w[9];
        return c;
    endfunction

    task automatic check_ports(input ecwm_image_type w);
        for (int p = 0; p < ECWM_PORTS; p++) begin
            check("port_cfg", CW'(o_port_cfg[p]), CW'(exp_map(w)));
        end
    endtask

    task automatic check_status(input logic [3:0] cnt, input logic used);
        check("load_done", CW'(o_load_done), CW'(1'b1));
        check("load_busy", CW'(o_load_busy), CW'(1'b0));
        check("words_taken", CW'(o_words_taken), CW'(cnt));
        check("image_used", CW'(o_image_used), CW'(used));
    endtask

    task automatic run_load(input ecwm_image_type w, input logic good, input logic slow,
                            input logic junk);
        ecwm_eeprom_model_inst.send(w, good, slow, junk);
        for (int n = 0; n < 20; n++) begin
            @(posedge i_sys_clk);
            #1;
            if (o_load_done === 1'b1) begin
                break;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // defaults stand before any load
    task automatic test_reset();
        #1;
        check_ports(IMG_DEF);
        check("load_done", CW'(o_load_done), CW'(1'b0));
    endtask

    // back-to-back words, last word shares its cycle with the end pulse
    task automatic test_full_load();
        run_load(IMG_A, 1'b1, 1'b0, 1'b0);
        check_ports(IMG_A);
        check_status(4'hA, 1'b1);
    endtask

    // inverted pattern with gaps and unmapped addresses that must be dropped
    task automatic test_refused_words();
        run_load(~IMG_A, 1'b1, 1'b1, 1'b1);
        check_ports(~IMG_A);
        check_status(4'hA, 1'b1);
    endtask

    // bad signature: nothing is taken and the stored words stay
    task automatic test_invalid_image();
        run_load(IMG_DEF, 1'b0, 1'b0, 1'b0);
        check_ports(~IMG_A);
        check_status(4'h0, 1'b0);
    endtask

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        failures = 0;
        total_checks = 0;
        cycles = 0;
        i_rstn = 1'b0;
        repeat (8) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        test_reset();
        @(posedge i_sys_clk);
        test_full_load();
        test_refused_words();
        test_invalid_image();
        finish_test();
    end
endmodule
`default_nettype wire
